// [src/unr_status.sv]
// Pipe not-ready status, side flags and interrupt request with AXI4-Lite registers
//
// Operation
// - Status bits clear at reset; software writes zero to clear a pipe bit.
// - A pipe bit sets only when the pipe response is buffer-response.
// - Host mode setup transactions never raise not-ready requests.
// - Function mode raises nothing during control status stage.
// - Host iso transmit empty at OUT time: zero-length packet, bit, overrun.
// - Host non-iso transmit timeout or three errors: bit set, response STALL.
// - Host STALL to OUT or PING outside setup: bit set, response STALL.
// - Host iso receive full at IN time: discard, bit, overrun, packet-error flag on data error.
// - Host non-iso receive timeout or three errors: bit set, response NAK.
// - Host iso receive timeout or error: bit set, response untouched.
// - Host iso receive CRC or stuffing error: bit and CRC flag.
// - Split iso with no data or space: bit and overrun at start-split.
// - Split non-iso transmit hub failure: bit, NAK, clear phase flag on complete-split.
// - Complete-split STALL: bit, response STALL, split phase flag cleared.
// - Split interrupt transmit NYET in microframe 4: bit, phase flag cleared.
// - Split bulk or control receive hub failure: bit, NAK, phase clear on complete.
// - Complete-split interrupt failure: NAK; iso failure: CRC flag; phase cleared.
// - Complete-split iso or interrupt receive NYET microframe 4: bit, CRC, phase clear.
// - Function IN token on empty buffer: bit; iso adds zero-length packet, overrun.
// - Function OUT with no space: iso bit, overrun; others on clean NAK.
// - Function PING with no space sets bit; missed iso token sets at SOF.
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none

module unr_status #(
  parameter int unsigned NPIPE  = 10,
  parameter int unsigned PIPE_W = 4
) (
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr_i,
  input  wire logic [2:0]        s_axi_awprot_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [7:0]        s_axi_araddr_i,
  input  wire logic [2:0]        s_axi_arprot_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Transaction events from the protocol engine (same clock)
  input  wire logic              evt_valid_i,
  input  wire logic [PIPE_W-1:0] evt_pipe_i,
  input  wire unr_pkg::unr_event_t evt_kind_i,
  input  wire unr_pkg::unr_xfer_t  evt_xfer_i,
  input  wire logic              evt_tx_i,
  input  wire logic              evt_split_i,
  input  wire logic              evt_csplit_i,
  input  wire logic              evt_setup_i,
  input  wire logic              evt_status_stage_i,
  input  wire logic [2:0]        evt_uframe_i,
  input  wire logic              evt_data_err_i,
  input  wire logic              evt_retx_i,
  input  wire logic [NPIPE-1:0]  pipe_resp_buf_i,
  // Actions back to the protocol engine and pipe control
  output logic                   pipe_stall_event_o,
  output logic [PIPE_W-1:0]      action_pipe_o,
  output logic                   force_nak_o,
  output logic                   force_stall_o,
  output logic                   split_complete_phase_clear_o,
  output logic                   send_zlp_o,
  output logic                   discard_data_o,
  output logic                   host_mode_o,
  output logic                   pipe_stall_event_irq_o
);
  import unr_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == UNR_OFS_STATUS) || (a == UNR_OFS_ENABLE) ||
           (a == UNR_OFS_FLAGS) || (a == UNR_OFS_MODE);
  endfunction

  // ==========================================================================
  // Storage
  logic [NPIPE-1:0] pipe_not_ready_status;
  logic [NPIPE-1:0] irq_enable;
  logic             overrun_flag;
  logic             crc_error_flag;
  logic             iso_receive_packet_error_flag;
  logic             host_mode;
  logic [1:0]       err_cnt [NPIPE];

  unr_wstate_t      wstate;
  logic             aw_held;
  logic             w_held;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             wr_fire;
  logic [31:0]      wr_clr;
  logic [31:0]      wr_mask;

  assign wr_fire = aw_held && w_held && (wstate == WS_IDLE);
  assign wr_mask = lane_mask(w_strb);
  // Write-zero-clear only acts on bits in enabled byte lanes
  assign wr_clr  = ~w_data & wr_mask;

  // ==========================================================================
  // AXI4-Lite write channel
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_axi_awready_o <= 1'b0;
      aw_held         <= 1'b0;
      aw_addr         <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_axi_awready_o <= 1'b0;
      aw_held         <= 1'b1;
      aw_addr         <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (!aw_held && (wstate == WS_IDLE)) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_axi_wready_o <= 1'b0;
      w_held         <= 1'b0;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_axi_wready_o <= 1'b0;
      w_held         <= 1'b1;
      w_data         <= s_axi_wdata_i;
      w_strb         <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (!w_held && (wstate == WS_IDLE)) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wstate         <= WS_IDLE;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= UNR_RESP_OKAY;
    end else begin
      case (wstate)
        WS_IDLE: begin
          if (wr_fire) begin
            wstate         <= WS_RESP;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= is_mapped(aw_addr) ? UNR_RESP_OKAY : UNR_RESP_SLVERR;
          end
        end
        WS_RESP: begin
          if (s_axi_bready_i) begin
            wstate         <= WS_IDLE;
            s_axi_bvalid_o <= 1'b0;
          end
        end
        default: begin
          wstate         <= WS_IDLE;
          s_axi_bvalid_o <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr_i)
      UNR_OFS_STATUS: rd_mux[NPIPE-1:0] = pipe_not_ready_status;
      UNR_OFS_ENABLE: rd_mux[NPIPE-1:0] = irq_enable;
      UNR_OFS_FLAGS: begin
        rd_mux[UNR_FLAG_OVERRUN] = overrun_flag;
        rd_mux[UNR_FLAG_CRC]     = crc_error_flag;
        rd_mux[UNR_FLAG_ISO_PKT] = iso_receive_packet_error_flag;
      end
      UNR_OFS_MODE:   rd_mux[UNR_MODE_HOST] = host_mode;
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= UNR_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_mux;
      s_axi_rresp_o   <= is_mapped(s_axi_araddr_i) ? UNR_RESP_OKAY : UNR_RESP_SLVERR;
    end else if (s_axi_rvalid_o) begin
      if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end else begin
      s_axi_arready_o <= 1'b1;
    end
  end

  // ==========================================================================
  // Consecutive error counting per pipe
  logic is_err;
  logic err3;
  logic fail;
  logic pipe_ok;

  assign pipe_ok = (32'(evt_pipe_i) < NPIPE);
  assign is_err  = (evt_kind_i == EV_PKT_ERR) || (evt_kind_i == EV_CRC_ERR);
  assign err3    = is_err && pipe_ok && (err_cnt[evt_pipe_i] == UNR_ERR_LIMIT - 2'h1);
  assign fail    = (evt_kind_i == EV_TIMEOUT) || err3;

  generate
    for (genvar p = 0; p < NPIPE; p++) begin : g_err
      always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
          err_cnt[p] <= 2'h0;
        end else if (evt_valid_i && (32'(evt_pipe_i) == p)) begin
          // Any good handshake or a reported failure restarts the run
          if (err3 || (evt_kind_i == EV_OK) || (evt_kind_i == EV_TIMEOUT)) begin
            err_cnt[p] <= 2'h0;
          end else if (is_err) begin
            err_cnt[p] <= err_cnt[p] + 2'h1;
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Not-ready decision
  logic req;
  logic set_ovr;
  logic set_crc;
  logic set_pkt;
  logic do_nak;
  logic do_stall;
  logic do_clr;
  logic do_zlp;
  logic do_discard;
  logic iso;
  logic intr;
  logic last_ufr;

  assign iso      = (evt_xfer_i == TT_ISO);
  assign intr     = (evt_xfer_i == TT_INTR);
  assign last_ufr = (evt_uframe_i == UNR_LAST_CSPLIT_UFR);

  always_comb begin
    {req, set_ovr, set_crc, set_pkt, do_nak, do_stall, do_clr, do_zlp, do_discard} = 9'h000;
    if (host_mode) begin
      if (!evt_setup_i) begin
        if (!evt_split_i) begin
          if (evt_tx_i) begin
            if (iso && (evt_kind_i == EV_NO_BUF)) {req, set_ovr, do_zlp} = 3'h7;
            if (!iso && fail) {req, do_stall} = 2'h3;
            if (evt_kind_i == EV_STALL) {req, do_stall} = 2'h3;
          end else begin
            if (iso && (evt_kind_i == EV_NO_BUF)) {req, set_ovr, do_discard, set_pkt} = {3'h7, evt_data_err_i};
            if (!iso && fail) {req, do_nak} = 2'h3;
            if (iso && ((evt_kind_i == EV_TIMEOUT) || is_err)) req = 1'b1;
            if (iso && (evt_kind_i == EV_CRC_ERR)) {req, set_crc} = 2'h3;
            if (evt_kind_i == EV_STALL) {req, do_stall} = 2'h3;
          end
        end else begin
          if (iso && (evt_kind_i == EV_NO_BUF))
            {req, set_ovr, do_zlp, do_discard} = {2'h3, evt_tx_i, !evt_tx_i};
          if (evt_tx_i) begin
            if (!iso && fail) {req, do_nak, do_clr} = {2'h3, evt_csplit_i};
            if (evt_csplit_i && (evt_kind_i == EV_STALL)) {req, do_stall, do_clr} = 3'h7;
            if (intr && evt_csplit_i && (evt_kind_i == EV_NYET) && last_ufr) {req, do_clr} = 2'h3;
          end else begin
            if (((evt_xfer_i == TT_BULK) || (evt_xfer_i == TT_CTRL)) && fail)
              {req, do_nak, do_clr} = {2'h3, evt_csplit_i};
            if (evt_csplit_i && intr && fail) {req, do_nak, do_clr} = 3'h7;
            if (evt_csplit_i && iso && fail) {req, set_crc, do_clr} = 3'h7;
            if (evt_csplit_i && !iso && (evt_kind_i == EV_STALL)) {req, do_stall, do_clr} = 3'h7;
            if (evt_csplit_i && (iso || intr) && (evt_kind_i == EV_NYET) && last_ufr)
              {req, set_crc, do_clr} = 3'h7;
          end
        end
      end
    end else if (!evt_status_stage_i) begin
      if (evt_tx_i) begin
        if (evt_kind_i == EV_NO_BUF) {req, set_ovr, do_zlp} = {1'b1, iso, iso};
      end else begin
        if (iso && (evt_kind_i == EV_NO_BUF)) {req, set_ovr} = 2'h3;
        // Retransmitted or corrupt data is no real overflow
        if (!iso && (evt_kind_i == EV_NAK_SENT) && !evt_retx_i && !evt_data_err_i) req = 1'b1;
        if (evt_kind_i == EV_PING_FULL) req = 1'b1;
        if (iso && (evt_kind_i == EV_SOF_MISS)) req = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Qualification and status update
  logic             act;
  logic [NPIPE-1:0] set_vec;
  logic             wr_status;
  logic             wr_flags;

  // Pipes not in buffer-response mode set no status, flag or action pulse; their error runs are still counted
  assign act       = evt_valid_i && pipe_ok && req && pipe_resp_buf_i[evt_pipe_i];
  assign set_vec   = act ? (NPIPE'(1) << evt_pipe_i) : '0;
  assign wr_status = wr_fire && (aw_addr == UNR_OFS_STATUS);
  assign wr_flags  = wr_fire && (aw_addr == UNR_OFS_FLAGS);

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pipe_not_ready_status <= UNR_RST_STATUS[NPIPE-1:0];
    end else begin
      // A new event in the clearing cycle survives the clear
      pipe_not_ready_status <= (pipe_not_ready_status &
                                ~(wr_status ? wr_clr[NPIPE-1:0] : '0)) | set_vec;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      overrun_flag                  <= UNR_RST_FLAGS[UNR_FLAG_OVERRUN];
      crc_error_flag                <= UNR_RST_FLAGS[UNR_FLAG_CRC];
      iso_receive_packet_error_flag <= UNR_RST_FLAGS[UNR_FLAG_ISO_PKT];
    end else begin
      overrun_flag <= (overrun_flag & ~(wr_flags & wr_clr[UNR_FLAG_OVERRUN])) | (act & set_ovr);
      crc_error_flag <= (crc_error_flag & ~(wr_flags & wr_clr[UNR_FLAG_CRC])) | (act & set_crc);
      iso_receive_packet_error_flag <= (iso_receive_packet_error_flag &
                                        ~(wr_flags & wr_clr[UNR_FLAG_ISO_PKT])) | (act & set_pkt);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      irq_enable <= UNR_RST_ENABLE[NPIPE-1:0];
      host_mode  <= UNR_RST_HOST;
    end else if (wr_fire) begin
      if (aw_addr == UNR_OFS_ENABLE) begin
        irq_enable <= (irq_enable & ~wr_mask[NPIPE-1:0]) | (w_data[NPIPE-1:0] & wr_mask[NPIPE-1:0]);
      end
      if ((aw_addr == UNR_OFS_MODE) && w_strb[0]) begin
        host_mode <= w_data[UNR_MODE_HOST];
      end
    end
  end

  // ==========================================================================
  // Registered action outputs, one-cycle pulses; action pipe, host mode and interrupt request are levels
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pipe_stall_event_o           <= 1'b0;
      action_pipe_o                <= '0;
      force_nak_o                  <= 1'b0;
      force_stall_o                <= 1'b0;
      split_complete_phase_clear_o <= 1'b0;
      send_zlp_o                   <= 1'b0;
      discard_data_o               <= 1'b0;
      host_mode_o                  <= UNR_RST_HOST;
      pipe_stall_event_irq_o                   <= 1'b0;
    end else begin
      pipe_stall_event_o           <= act;
      action_pipe_o                <= evt_pipe_i;
      force_nak_o                  <= act & do_nak;
      force_stall_o                <= act & do_stall;
      split_complete_phase_clear_o <= act & do_clr;
      send_zlp_o                   <= act & do_zlp;
      discard_data_o               <= act & do_discard;
      host_mode_o                  <= host_mode;
      pipe_stall_event_irq_o                   <= |(pipe_not_ready_status & irq_enable);
    end
  end

endmodule // unr_status

`default_nettype wire

// [src/unr_pkg.sv]
// Constants and types for the pipe not-ready status block
package unr_pkg;

  // ==========================================================================
  // Register map (byte addresses on the AXI4-Lite slave)
  localparam logic [7:0] UNR_OFS_STATUS = 8'h00;
  localparam logic [7:0] UNR_OFS_ENABLE = 8'h04;
  localparam logic [7:0] UNR_OFS_FLAGS  = 8'h08;
  localparam logic [7:0] UNR_OFS_MODE   = 8'h0c;

  // ==========================================================================
  // Field positions
  localparam int unsigned UNR_FLAG_OVERRUN = 0;
  localparam int unsigned UNR_FLAG_CRC     = 1;
  localparam int unsigned UNR_FLAG_ISO_PKT = 2;
  localparam int unsigned UNR_MODE_HOST    = 0;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] UNR_RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] UNR_RST_ENABLE = 32'h0000_0000;
  localparam logic [2:0]  UNR_RST_FLAGS  = 3'h0;
  localparam logic        UNR_RST_HOST   = 1'b0;

  // ==========================================================================
  // Protocol figures
  localparam logic [1:0] UNR_ERR_LIMIT       = 2'h3;
  localparam logic [2:0] UNR_LAST_CSPLIT_UFR = 3'h4;

  // AXI response codes
  localparam logic [1:0] UNR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UNR_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    EV_OK        = 4'h0,
    EV_PKT_ERR   = 4'h1,
    EV_TIMEOUT   = 4'h2,
    EV_STALL     = 4'h3,
    EV_NYET      = 4'h4,
    EV_NO_BUF    = 4'h5,
    EV_CRC_ERR   = 4'h6,
    EV_NAK_SENT  = 4'h7,
    EV_PING_FULL = 4'h8,
    EV_SOF_MISS  = 4'h9
  } unr_event_t;

  typedef enum logic [1:0] {
    TT_CTRL = 2'b00,
    TT_ISO  = 2'b01,
    TT_BULK = 2'b10,
    TT_INTR = 2'b11
  } unr_xfer_t;

  typedef enum logic [0:0] {
    WS_IDLE = 1'b0,
    WS_RESP = 1'b1
  } unr_wstate_t;

endpackage

// [tb/unr_status_checker.sv]
// Port-level assertions for the pipe not-ready status block
`timescale 1ns/10ps
`default_nettype none
module unr_status_checker #(
  parameter int unsigned NPIPE  = 10,
  parameter int unsigned PIPE_W = 4
) (
  input wire logic                sys_clk_i,
  input wire logic                nrst_i,
  input wire logic                evt_valid_i,
  input wire logic [PIPE_W-1:0]   evt_pipe_i,
  input wire unr_pkg::unr_event_t evt_kind_i,
  input wire unr_pkg::unr_xfer_t  evt_xfer_i,
  input wire logic                evt_tx_i,
  input wire logic                evt_split_i,
  input wire logic                evt_csplit_i,
  input wire logic                evt_setup_i,
  input wire logic                evt_status_stage_i,
  input wire logic [2:0]          evt_uframe_i,
  input wire logic [NPIPE-1:0]    pipe_resp_buf_i,
  input wire logic                host_mode_o,
  input wire logic                pipe_stall_event_o,
  input wire logic [PIPE_W-1:0]   action_pipe_o,
  input wire logic                force_nak_o,
  input wire logic                force_stall_o,
  input wire logic                split_complete_phase_clear_o
);
  import unr_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ====================
  // Qualified events: in-range buffer-response pipe, no setup
  wire logic hit = evt_valid_i && evt_pipe_i < PIPE_W'(NPIPE) && pipe_resp_buf_i[evt_pipe_i] && !evt_setup_i;
  wire logic hns = hit && host_mode_o && !evt_split_i;
  wire logic hcs = hit && host_mode_o && evt_split_i && evt_csplit_i;
  // ====================
  // Properties
  property p_buf_only; evt_valid_i && !pipe_resp_buf_i[evt_pipe_i] |=> !pipe_stall_event_o; endproperty
  a_buf_only: assert property (p_buf_only) else $error("pulse on non-buffer pipe");
  property p_cause; pipe_stall_event_o |-> $past(evt_valid_i) && action_pipe_o == $past(evt_pipe_i); endproperty
  a_cause: assert property (p_cause) else $error("pulse without event");
  property p_side; force_nak_o || force_stall_o || split_complete_phase_clear_o
    |-> pipe_stall_event_o && !(force_nak_o && force_stall_o); endproperty
  a_side: assert property (p_side) else $error("stray side pulse");
  property p_setup; evt_valid_i && host_mode_o && evt_setup_i |=> !pipe_stall_event_o; endproperty
  a_setup: assert property (p_setup) else $error("pulse on host setup");
  property p_stage; evt_valid_i && !host_mode_o && evt_status_stage_i |=> !pipe_stall_event_o; endproperty
  a_stage: assert property (p_stage) else $error("pulse in status stage");
  property p_tx_fail; hns && evt_tx_i && evt_xfer_i != TT_ISO && evt_kind_i == EV_TIMEOUT |=> force_stall_o; endproperty
  a_tx_fail: assert property (p_tx_fail) else $error("tx timeout not stalled");
  property p_rx_fail; hns && !evt_tx_i && evt_xfer_i != TT_ISO && evt_kind_i == EV_TIMEOUT |=> force_nak_o; endproperty
  a_rx_fail: assert property (p_rx_fail) else $error("rx timeout not naked");
  property p_iso_rx; hns && !evt_tx_i && evt_xfer_i == TT_ISO && evt_kind_i == EV_TIMEOUT
    |=> pipe_stall_event_o && !force_nak_o && !force_stall_o; endproperty
  a_iso_rx: assert property (p_iso_rx) else $error("iso rx timeout wrong");
  property p_cs_stall; hcs && evt_kind_i == EV_STALL && evt_xfer_i != TT_ISO
    |=> force_stall_o && split_complete_phase_clear_o; endproperty
  a_cs_stall: assert property (p_cs_stall) else $error("split stall wrong");
  property p_nyet4; hcs && evt_kind_i == EV_NYET && evt_uframe_i == 3'h4 && evt_xfer_i == TT_INTR
    |=> split_complete_phase_clear_o && !force_nak_o && !force_stall_o; endproperty
  a_nyet4: assert property (p_nyet4) else $error("late nyet wrong");
endmodule // unr_status_checker
`default_nettype wire

// [tb/unr_engine_model.sv]
// Protocol engine stand-in issuing one event per command
`timescale 1ns/10ps
`default_nettype none
module unr_engine_model (
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        go_i,
  input  wire logic [19:0] cmd_i,
  output logic             evt_valid_o,
  output logic [19:0]      evt_o
);
  // Fields invert while idle so stale values never pass for a request
  always_ff @(posedge sys_clk_i) begin
    evt_valid_o <= nrst_i && go_i;
    evt_o       <= go_i ? cmd_i : ~evt_o;
  end
endmodule // unr_engine_model
`default_nettype wire

// [tb/tb_usb_pipe_not_ready_status.sv]
// Self-checking bench for the pipe not-ready status block
`timescale 1ns/10ps
`default_nettype none
module tb_usb_pipe_not_ready_status;
  import unr_pkg::*;
  logic        sys_clk_i, nrst_i, go, evt_valid_i;
  logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic        pipe_stall_event_o, force_nak_o, force_stall_o, split_complete_phase_clear_o;
  logic        send_zlp_o, discard_data_o, host_mode_o, pipe_stall_event_irq_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
  logic [3:0]  action_pipe_o;
  logic [5:0]  o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [9:0]  pipe_resp_buf_i;
  logic [19:0] cmd, ev;
  logic [28:0] rows [23];
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d, st;
  int          error_cnt, checks_done;
  wire logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0, evt_uframe_i = ev[4:2];
  wire logic [3:0] s_axi_wstrb_i = 4'hf, evt_pipe_i = ev[19:16];
  wire unr_event_t evt_kind_i = unr_event_t'(ev[15:12]);
  wire unr_xfer_t  evt_xfer_i = unr_xfer_t'(ev[11:10]);
  wire logic evt_tx_i = ev[9], evt_split_i = ev[8], evt_csplit_i = ev[7], evt_setup_i = ev[6];
  wire logic evt_status_stage_i = ev[5], evt_data_err_i = ev[1], evt_retx_i = ev[0];

  unr_status dut (.*);
  unr_engine_model u_eng (.sys_clk_i, .nrst_i, .go_i(go), .cmd_i(cmd), .evt_valid_o(evt_valid_i), .evt_o(ev));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // ====================
  // Tasks
  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic tmo(input int n);
    if (n > 40) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  // Ready lines are held high throughout, so no release races a new request
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= v;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
      tmo(n);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    r = s_axi_bresp_o;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
      tmo(n);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
  endtask

  task automatic send(input logic [19:0] c);
    cmd <= c;
    go  <= 1'b1;
    @(posedge sys_clk_i);
    go <= 1'b0;
    @(posedge sys_clk_i);
    #1 o = {pipe_stall_event_o, force_nak_o, force_stall_o, split_complete_phase_clear_o, send_zlp_o, discard_data_o};
    @(posedge sys_clk_i);
  endtask

  // ====================
  // Sequence: rows 0..16 host mode, the rest function mode
  initial begin
    {nrst_i, go, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i} = 5'h0;
    {s_axi_bready_i, s_axi_rready_i} = 2'h3;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, cmd} = 68'h0;
    pipe_resp_buf_i = 10'h1ff;
    error_cnt = 0;
    checks_done = 0;
    rows = '{
      {4'h1, EV_NO_BUF, TT_ISO, 10'h200, 6'h22, 3'h1},
      {4'h2, EV_TIMEOUT, TT_BULK, 10'h200, 6'h28, 3'h0},
      {4'h2, EV_STALL, TT_BULK, 10'h200, 6'h28, 3'h0},
      {4'h3, EV_NO_BUF, TT_ISO, 10'h002, 6'h21, 3'h5},
      {4'h4, EV_TIMEOUT, TT_INTR, 10'h000, 6'h30, 3'h0},
      {4'h5, EV_TIMEOUT, TT_ISO, 10'h000, 6'h20, 3'h0},
      {4'h5, EV_CRC_ERR, TT_ISO, 10'h000, 6'h20, 3'h2},
      {4'h6, EV_NO_BUF, TT_ISO, 10'h300, 6'h22, 3'h1},
      {4'h7, EV_TIMEOUT, TT_BULK, 10'h380, 6'h34, 3'h0},
      {4'h7, EV_STALL, TT_INTR, 10'h180, 6'h2c, 3'h0},
      {4'h8, EV_NYET, TT_INTR, 10'h390, 6'h24, 3'h0},
      {4'h0, EV_TIMEOUT, TT_CTRL, 10'h180, 6'h34, 3'h0},
      {4'h1, EV_TIMEOUT, TT_INTR, 10'h180, 6'h34, 3'h0},
      {4'h1, EV_TIMEOUT, TT_ISO, 10'h180, 6'h24, 3'h2},
      {4'h3, EV_NYET, TT_ISO, 10'h190, 6'h24, 3'h2},
      {4'h2, EV_STALL, TT_BULK, 10'h240, 6'h00, 3'h0},
      {4'h9, EV_TIMEOUT, TT_BULK, 10'h200, 6'h00, 3'h0},
      {4'h1, EV_NO_BUF, TT_ISO, 10'h200, 6'h22, 3'h1},
      {4'h4, EV_NAK_SENT, TT_BULK, 10'h000, 6'h20, 3'h0},
      {4'h4, EV_NAK_SENT, TT_BULK, 10'h001, 6'h00, 3'h0},
      {4'h6, EV_PING_FULL, TT_BULK, 10'h000, 6'h20, 3'h0},
      {4'h8, EV_SOF_MISS, TT_ISO, 10'h000, 6'h20, 3'h0},
      {4'h0, EV_NAK_SENT, TT_CTRL, 10'h020, 6'h00, 3'h0}};
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i));
      chk(d, 32'h0);
    end
    wr(UNR_OFS_ENABLE, 32'h3ff);
    st = 32'h0;
    foreach (rows[i]) begin
      wr(UNR_OFS_MODE, (i < 17) ? 32'h1 : 32'h0);
      send(rows[i][28:9]);
      chk(o, rows[i][8:3]);
      chk(host_mode_o, i < 17);
      if (rows[i][8]) st[rows[i][28:25]] = 1'b1;
      rd(UNR_OFS_FLAGS);
      chk(d, rows[i][2:0]);
      wr(UNR_OFS_FLAGS, 32'h0);
    end
    wr(UNR_OFS_MODE, 32'h1);
    for (int i = 0; i < 4; i++) begin
      send({4'h4, (i == 0) ? EV_OK : EV_PKT_ERR, TT_BULK, 10'h000});
      chk(o, (i == 3) ? 32'h30 : 32'h0);
    end
    rd(UNR_OFS_STATUS);
    chk(d, st);
    chk(pipe_stall_event_irq_o, 1'b1);
    wr(UNR_OFS_STATUS, 32'hffff_fffe);
    rd(UNR_OFS_STATUS);
    chk(d, st & 32'hffff_fffe);
    wr(UNR_OFS_ENABLE, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    chk(pipe_stall_event_irq_o, 1'b0);
    rd(8'h10);
    chk(d, 32'h0);
    chk(r, UNR_RESP_SLVERR);
    wr(8'h10, 32'h1);
    chk(r, UNR_RESP_SLVERR);
    nrst_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(UNR_OFS_STATUS);
    chk(d, 32'h0);
    wrap_up();
  end
endmodule // tb_usb_pipe_not_ready_status

bind unr_status unr_status_checker #(.NPIPE(NPIPE), .PIPE_W(PIPE_W)) u_chk (.*);
`default_nettype wire
